/* File: pkg/asmr_pkg.sv */
// Package with the map, field layout, reset values and carriers of the status and mode registers.
package asmr_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [5:0] ADDR_DEVICE_IDENTITY = 6'h00;
  localparam logic [5:0] ADDR_STATUS_FLAGS    = 6'h01;
  localparam logic [5:0] ADDR_MODE_CONTROL    = 6'h02;

  // ****************************************************************
  // Identification contents
  // ****************************************************************
  // Upper nibble code: the value is arbitrary.
  localparam logic [3:0] ID_FAMILY_CODE      = 4'h5;
  localparam logic [3:0] CHANNEL_COUNT_FIELD = 4'h8;
  // Revision byte: the value is arbitrary.
  localparam logic [7:0] ID_REVISION_CODE    = 8'hA5;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_LOCK          = 15;
  localparam int BIT_REALIGN       = 14;
  localparam int BIT_REGMAP_CHG    = 13;
  localparam int BIT_RX_CRC_ERR    = 12;
  localparam int BIT_CRC_TYPE      = 11;
  localparam int BIT_RESET_SEEN    = 10;
  localparam int BIT_WORD_SIZE_HI  = 9;
  localparam int BIT_WORD_SIZE_LO  = 8;
  localparam int BIT_SRC_SEL_HI    = 3;
  localparam int BIT_SRC_SEL_LO    = 2;
  localparam int BIT_IDLE_FLOAT    = 1;
  localparam int BIT_PULSE_FORMAT  = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] STATUS_RST = 16'h0500;
  localparam logic [15:0] MODE_RST   = 16'h0510;
  // Mode bits 15:14 always read zero.
  localparam logic [15:0] MODE_WMASK = 16'h3FFF;

  // ****************************************************************
  // Ready pin source selection
  // ****************************************************************
  localparam logic [1:0] SRC_LAGGING = 2'h0;
  localparam logic [1:0] SRC_ANY_OR  = 2'h1;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 5;
  localparam int PULSE_TIME_NS  = 40;
  localparam int PULSE_CYC      = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] PULSE_CYC_W = PULSE_CYC[3:0];

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [5:0]  addr;
    logic [15:0] wdata;
  } asmr_req_s;

  typedef struct packed {
    logic       lock;
    logic       resync;
    logic       regmap_chg;
    logic       rx_crc_err;
    logic [7:0] new_data;
    logic [7:0] data_taken;
    logic [7:0] ch_enable;
  } asmr_evt_s;

endpackage

/* File: verilog/asmr_sticky.sv */
// Bank of sticky flags in which a set wins over a clear in the same cycle.
`timescale 1ns/1ps

module asmr_sticky #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_set,
  input  wire logic [W-1:0] i_clr,
  output logic      [W-1:0] o_flag
);

  // Each flag holds until cleared; a set in the clear cycle is kept.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      o_flag <= RST_VAL;
    end
    else
    begin
      o_flag <= i_set | (o_flag & ~i_clr);
    end
  end

endmodule

/* File: verilog/asmr_regs.sv */
// Identification, status and mode registers with the sample-ready pin logic.
`timescale 1ns/1ps

// Overview of operation
// - Read-only identification word at address zero.
// - Low identification byte is revision dependent.
// - Status word at address one, resets 0500h.
// - Status bit 15 shows interface lock.
// - Status bit 14 set on each resynchronization.
// - Status bit 13 flags register checksum change.
// - Status bit 12 flags input checksum error.
// - Status bit 11 shows checksum polynomial type.
// - Status bit 10 set after any reset.
// - Status bits 9:8 show data word length.
// - Status bits 7:0 show per-channel new data.
// - Mode register at address two, resets 0510h.
// - Writing zero to mode bit 10 clears flag.
// - Mode bits 3:2 choose ready pin source.
// - Mode bit 1 floats idle ready pin.
// - Mode bit 0 selects level or pulse.

module asmr_regs (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rstn,
  input  wire asmr_pkg::asmr_req_s  i_req,
  input  wire asmr_pkg::asmr_evt_s  i_evt,
  output logic                      o_reg_ack,
  output logic [15:0]               o_reg_rdata,
  output logic                      o_sample_ready_pin,
  output logic                      o_sample_ready_pin_oe_n
);
  import asmr_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [15:0] mode_reg;
  logic        lock_state;
  logic [2:0]  event_flags;
  logic [0:0]  reset_seen;
  logic [7:0]  channel_new_data_flags;
  logic [15:0] status_word;
  logic [15:0] id_word;
  logic        status_rd;
  logic        mode_wr;
  logic        reset_clear;
  logic        ready_level;
  logic        ready_level_q;
  logic        pulse_active;
  logic [3:0]  pulse_cnt;
  logic        drive_low;
  logic [7:0]  en_flags;

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Only the mode address accepts writes; writes elsewhere are dropped.
  assign mode_wr     = i_req.wr && (i_req.addr == ADDR_MODE_CONTROL);
  assign status_rd   = i_req.rd && (i_req.addr == ADDR_STATUS_FLAGS);
  assign reset_clear = mode_wr && !i_req.wdata[BIT_RESET_SEEN];

  // ****************************************************************
  // Identification
  // ****************************************************************
  // Fixed word; nothing a host does can alter it.
  assign id_word = {ID_FAMILY_CODE, CHANNEL_COUNT_FIELD, ID_REVISION_CODE};

  // ****************************************************************
  // Mode register
  // ****************************************************************
  // Bit 10 is stored here but never read back; reads return the reset-seen flag.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      mode_reg <= MODE_RST;
    end
    else if (mode_wr)
    begin
      mode_reg <= i_req.wdata & MODE_WMASK;
    end
  end

  // ****************************************************************
  // Status sources
  // ****************************************************************
  // Lock level is registered so the status word is glitch free.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      lock_state <= 1'b0;
    end
    else
    begin
      lock_state <= i_evt.lock;
    end
  end

  // Resync, register checksum and input checksum flags clear on a status read.
  asmr_sticky #(
    .W       (3),
    .RST_VAL (3'h0)
  ) u_event_flags (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_set     ({i_evt.resync, i_evt.regmap_chg, i_evt.rx_crc_err}),
    .i_clr     ({3{status_rd}}),
    .o_flag    (event_flags)
  );

  // Reset-seen flag comes up set and only a host write of zero clears it.
  asmr_sticky #(
    .W       (1),
    .RST_VAL (1'h1)
  ) u_reset_seen (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_set     (1'b0),
    .i_clr     (reset_clear),
    .o_flag    (reset_seen)
  );

  // Per-channel new-data flags clear when that channel's data is taken.
  asmr_sticky #(
    .W       (8),
    .RST_VAL (8'h00)
  ) u_new_data (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_set     (i_evt.new_data),
    .i_clr     (i_evt.data_taken),
    .o_flag    (channel_new_data_flags)
  );

  // Status word assembly; type and word size mirror the mode settings.
  always_comb
  begin
    status_word                   = 16'h0000;
    status_word[BIT_LOCK]         = lock_state;
    status_word[BIT_REALIGN]      = event_flags[2];
    status_word[BIT_REGMAP_CHG]   = event_flags[1];
    status_word[BIT_RX_CRC_ERR]   = event_flags[0];
    status_word[BIT_CRC_TYPE]     = mode_reg[BIT_CRC_TYPE];
    status_word[BIT_RESET_SEEN]   = reset_seen[0];
    status_word[BIT_WORD_SIZE_HI] = mode_reg[BIT_WORD_SIZE_HI];
    status_word[BIT_WORD_SIZE_LO] = mode_reg[BIT_WORD_SIZE_LO];
    status_word[7:0]              = channel_new_data_flags;
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  // Read data and acknowledge appear one cycle after the request.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      o_reg_ack   <= 1'b0;
      o_reg_rdata <= 16'h0000;
    end
    else
    begin
      o_reg_ack <= i_req.rd || i_req.wr;
      if (i_req.rd)
      begin
        unique case (i_req.addr)
          ADDR_DEVICE_IDENTITY: o_reg_rdata <= id_word;
          ADDR_STATUS_FLAGS:    o_reg_rdata <= status_word;
          ADDR_MODE_CONTROL:    o_reg_rdata <= {mode_reg[15:11], reset_seen[0], mode_reg[9:0]};
          default:              o_reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Sample-ready pin
  // ****************************************************************
  // Source selection over the enabled channels only.
  assign en_flags = channel_new_data_flags & i_evt.ch_enable;

  always_comb
  begin
    ready_level = 1'b0;
    if (i_evt.ch_enable != 8'h00)
    begin
      if (mode_reg[BIT_SRC_SEL_HI:BIT_SRC_SEL_LO] == SRC_LAGGING)
      begin
        ready_level = &(channel_new_data_flags | ~i_evt.ch_enable);
      end
      else
      begin
        ready_level = |en_flags;
      end
    end
  end

  // A rising ready level starts one fixed-length low pulse.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      ready_level_q <= 1'b0;
      pulse_active  <= 1'b0;
      pulse_cnt     <= 4'h0;
    end
    else
    begin
      ready_level_q <= ready_level;
      if (ready_level && !ready_level_q)
      begin
        pulse_active <= 1'b1;
        pulse_cnt    <= PULSE_CYC_W;
      end
      else if (pulse_cnt > 4'h1)
      begin
        pulse_cnt <= pulse_cnt - 4'h1;
      end
      else
      begin
        pulse_active <= 1'b0;
        pulse_cnt    <= 4'h0;
      end
    end
  end

  // Level format holds low while data waits; pulse format only for the pulse.
  assign drive_low = mode_reg[BIT_PULSE_FORMAT] ? pulse_active : ready_level;

  // Idle pin is driven high or released, as the float bit says.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      o_sample_ready_pin      <= 1'b1;
      o_sample_ready_pin_oe_n <= 1'b0;
    end
    else
    begin
      o_sample_ready_pin      <= !drive_low;
      o_sample_ready_pin_oe_n <= !drive_low && mode_reg[BIT_IDLE_FLOAT];
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_id_read_fixed: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (i_req.rd && i_req.addr == ADDR_DEVICE_IDENTITY)
    |=> (o_reg_rdata == {ID_FAMILY_CODE, CHANNEL_COUNT_FIELD, ID_REVISION_CODE}))
    else $error("identification read returned a wrong word");

  a_status_reset_val: assert property (@(posedge i_clk_sys)
    !i_rstn |=> (status_word == STATUS_RST))
    else $error("status word not at reset value after reset");

  a_lock_follows: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    ##1 (status_word[BIT_LOCK] == $past(i_evt.lock)))
    else $error("lock bit does not follow lock state");

  a_resync_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_evt.resync |=> status_word[BIT_REALIGN] ##1 (status_word[BIT_REALIGN] || $past(status_rd)))
    else $error("resync flag lost");

  a_regmap_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_evt.regmap_chg |=> status_word[BIT_REGMAP_CHG])
    else $error("register checksum flag not set");

  a_crc_err_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (i_evt.rx_crc_err && status_rd) |=> status_word[BIT_RX_CRC_ERR])
    else $error("input checksum error lost against clear");

  a_copy_fields: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    mode_wr |=> (status_word[11:8] == {$past(i_req.wdata[11]), $past(reset_seen[0]) && $past(i_req.wdata[10]),
                                       $past(i_req.wdata[9:8])}))
    else $error("status type or length not following mode");

  a_reset_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    reset_clear |=> !status_word[BIT_RESET_SEEN] && !reset_seen[0])
    else $error("reset flag not cleared by mode write");

  a_new_data_set: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (i_evt.new_data != 8'h00) |=> ((status_word[7:0] & $past(i_evt.new_data)) == $past(i_evt.new_data)))
    else $error("new data flag not set");

  a_mode_write: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    mode_wr |=> (mode_reg == ($past(i_req.wdata) & MODE_WMASK)))
    else $error("mode register write not stored");

  a_lagging_src: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (mode_reg[3:2] == SRC_LAGGING && i_evt.ch_enable != 8'h00 && !mode_reg[0]
     && ((channel_new_data_flags & i_evt.ch_enable) != i_evt.ch_enable)) |=> o_sample_ready_pin)
    else $error("lagging source asserted before all channels ready");

  a_idle_float: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (!drive_low && mode_reg[BIT_IDLE_FLOAT]) |=> (o_sample_ready_pin_oe_n && o_sample_ready_pin))
    else $error("idle ready pin not released");

  a_pulse_width: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (ready_level && !ready_level_q && mode_reg[0]) |=> pulse_active[*8])
    else $error("ready pulse shorter than its fixed length");

  // A new rise may restart the pulse, so the end is only checked while the level stays up.
  a_pulse_end: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (ready_level && !ready_level_q && mode_reg[0]) ##1 ready_level[*8] |=> !pulse_active)
    else $error("ready pulse longer than its fixed length");

endmodule

/* File: tb/asmr_host_model.sv */
// Host-side model that issues register reads and writes and watches the sample-ready line.
`timescale 1ns/1ps

module asmr_host_model (
  input  wire logic          i_clk_sys,
  input  wire logic          i_reg_ack,
  input  wire logic [15:0]   i_reg_rdata,
  input  wire logic          i_pin,
  input  wire logic          i_pin_oe_n,
  output asmr_pkg::asmr_req_s o_req,
  output logic               o_pin_level,
  output int                 o_ack_miss
);
  import asmr_pkg::*;

  // ****************************************************************
  // Line level and idle request
  // ****************************************************************
  // A board pull-up holds the ready line high whenever the device releases it.
  assign o_pin_level = i_pin_oe_n ? 1'b1 : i_pin;

  // Nothing is requested until the first access.
  initial
  begin
    o_req      = '0;
    o_ack_miss = 0;
  end

  // ****************************************************************
  // Register access
  // ****************************************************************
  // One request for one edge; the answer is taken in the following cycle.
  // Idle address and data show the inverse of their last value, so stale lines never look valid.
  task automatic access(input logic rd, input logic [5:0] addr, input logic [15:0] wdata,
                        output logic [15:0] rdata);
    @(negedge i_clk_sys);
    o_req = '{rd: rd, wr: ~rd, addr: addr, wdata: wdata};
    @(negedge i_clk_sys);
    if (i_reg_ack !== 1'b1)
      o_ack_miss++;
    rdata = i_reg_rdata;
    o_req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
  endtask
endmodule

/* File: tb/test_asmr_regs.sv */
// Self-checking bench for the identification, status and mode registers.
`timescale 1ns/1ps

`define CHK(what, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
    end \
  end

module test_asmr_regs;
  import asmr_pkg::*;

  logic        clk = 1'b0;
  logic        rstn;
  asmr_req_s   req;
  asmr_evt_s   evt;
  logic        ack;
  logic [15:0] rdata;
  logic        pin;
  logic        oe_n;
  logic        pin_level;
  int          ack_miss;
  int          err_total;
  int          checks_done;
  logic [15:0] id0;
  logic [15:0] w;
  logic [2:0]  k;
  logic [7:0]  cnt;

  // The clock toggles every half period of 2.5 ns.
  always #2.5 clk = ~clk;

  asmr_regs i_dut (
    .i_clk_sys              (clk),
    .i_rstn                 (rstn),
    .i_req                  (req),
    .i_evt                  (evt),
    .o_reg_ack              (ack),
    .o_reg_rdata            (rdata),
    .o_sample_ready_pin     (pin),
    .o_sample_ready_pin_oe_n(oe_n)
  );

  asmr_host_model i_host (
    .i_clk_sys  (clk),
    .i_reg_ack  (ack),
    .i_reg_rdata(rdata),
    .i_pin      (pin),
    .i_pin_oe_n (oe_n),
    .o_req      (req),
    .o_pin_level(pin_level),
    .o_ack_miss (ack_miss)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Reads a register and compares the masked value.
  task automatic xreg(input string what, input logic [5:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] v;
    i_host.access(1'b1, a, 16'h0000, v);
    `CHK(what, e & m, v & m)
  endtask

  // Writes a register.
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [15:0] v;
    i_host.access(1'b0, a, d, v);
  endtask

  // Pulses event flags for one cycle.
  task automatic fire(input logic [2:0] f, input logic [7:0] nd, input logic [7:0] tk);
    @(negedge clk);
    {evt.resync, evt.regmap_chg, evt.rx_crc_err, evt.new_data, evt.data_taken} = {f, nd, tk};
    @(negedge clk);
    {evt.resync, evt.regmap_chg, evt.rx_crc_err, evt.new_data, evt.data_taken} = '0;
  endtask

  // Compares release state and line level after the pin has had time to follow.
  task automatic pin_chk(input string what, input logic e_oe_n, input logic e_lvl);
    repeat (3) @(negedge clk);
    `CHK(what, {e_oe_n, e_lvl}, {oe_n, pin_level})
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  // Cuts a hang short well beyond the fewer than two hundred cycles the sequence needs.
  initial
  begin
    #25000;
    err_total++;
    close_out();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  // Reset, then the register and pin scenarios in turn.
  initial
  begin
    rstn        = 1'b0;
    evt         = '0;
    err_total   = 0;
    checks_done = 0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    pin_chk("pin idle", 1'b0, 1'b1);
    xreg("id upper", ADDR_DEVICE_IDENTITY, 16'hFF00, {ID_FAMILY_CODE, CHANNEL_COUNT_FIELD, 8'h00});
    i_host.access(1'b1, ADDR_DEVICE_IDENTITY, 16'h0000, id0);
    xreg("status reset", ADDR_STATUS_FLAGS, 16'hFFFF, 16'h0500);
    xreg("mode reset", ADDR_MODE_CONTROL, 16'hFFFF, 16'h0510);
    wr(ADDR_DEVICE_IDENTITY, 16'hFFFF);
    wr(ADDR_STATUS_FLAGS, 16'hFFFF);
    xreg("id after write", ADDR_DEVICE_IDENTITY, 16'hFFFF, id0);
    xreg("status after write", ADDR_STATUS_FLAGS, 16'hFFFF, 16'h0500);
    xreg("unmapped read", 6'h3F, 16'hFFFF, 16'h0000);
    @(negedge clk);
    evt.lock = 1'b1;
    xreg("lock on", ADDR_STATUS_FLAGS, 16'h8000, 16'h8000);
    evt.lock = 1'b0;
    xreg("lock off", ADDR_STATUS_FLAGS, 16'h8000, 16'h0000);
    // Each sticky event alone, then its clear by the read.
    for (k = 0; k < 3; k++)
    begin
      fire(3'h1 << k, 8'h00, 8'h00);
      xreg("event flag", ADDR_STATUS_FLAGS, 16'h7000, 16'h1000 << k);
      xreg("event cleared", ADDR_STATUS_FLAGS, 16'h7000, 16'h0000);
    end
    // Every word size and both checksum types; the first write keeps the reset flag.
    for (k = 0; k < 4; k++)
    begin
      w = {(k == 0) ? 2'h3 : 2'h0, 2'h0, k[0], k == 0, k[1:0], 8'h10};
      wr(ADDR_MODE_CONTROL, w);
      xreg("status mode copy", ADDR_STATUS_FLAGS, 16'h0F00, {4'h0, w[11], k == 0, w[9:8], 8'h00});
      xreg("mode readback", ADDR_MODE_CONTROL, 16'hFFFF, w & MODE_WMASK);
    end
    @(negedge clk);
    evt.ch_enable = 8'hFF;
    fire(3'h0, 8'hA5, 8'h00);
    xreg("new data", ADDR_STATUS_FLAGS, 16'h00FF, 16'h00A5);
    fire(3'h0, 8'h00, 8'hA5);
    xreg("data taken", ADDR_STATUS_FLAGS, 16'h00FF, 16'h0000);
    // All four source selections with one enabled channel, level format, driven idle.
    evt.ch_enable = 8'h01;
    for (k = 0; k < 4; k++)
    begin
      wr(ADDR_MODE_CONTROL, {8'h01, 4'h1, k[1:0], 2'h0});
      fire(3'h0, 8'h02, 8'h00);
      pin_chk("disabled channel", 1'b0, 1'b1);
      fire(3'h0, 8'h01, 8'h00);
      pin_chk("ready low", 1'b0, 1'b0);
      fire(3'h0, 8'h00, 8'h03);
      pin_chk("ready cleared", 1'b0, 1'b1);
    end
    // OR source, floating idle line, pulse format.
    evt.ch_enable = 8'h03;
    wr(ADDR_MODE_CONTROL, {8'h01, 4'h1, SRC_ANY_OR, 2'h3});
    pin_chk("float idle", 1'b1, 1'b1);
    fire(3'h0, 8'h02, 8'h00);
    cnt = 8'h00;
    repeat (20)
    begin
      @(negedge clk);
      if (oe_n === 1'b0 && pin_level === 1'b0)
        cnt++;
    end
    `CHK("pulse width", PULSE_CYC_W, cnt[3:0])
    fire(3'h0, 8'h00, 8'h03);
    // A second reset sets the reset flag again and restores both words.
    @(negedge clk);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    xreg("status after reset", ADDR_STATUS_FLAGS, 16'hFFFF, 16'h0500);
    xreg("mode after reset", ADDR_MODE_CONTROL, 16'hFFFF, 16'h0510);
    `CHK("ack misses", 0, ack_miss)
    close_out();
  end
endmodule
